/* File: msbc_top.sv */
// Modulation clock, bit-stream filters, trigger generator and SAR scan sequencer
`timescale 1ns/1ps
`default_nettype none

module msbc_top #(
  parameter int unsigned MOD_DIV = msbc_pkg::ModDiv,
  parameter int unsigned OSR     = msbc_pkg::Osr
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Modulator link
  output logic             modClk,
  input  wire logic [2:0]  bitstreamIn,
  // SAR converter analog side
  input  wire logic [9:0]  sarAnalogCode,
  output logic [3:0]       sarChannel,
  output logic             sarSampling,
  // Sample events
  output logic             sampleStrobe,
  output logic             scanDone
);

  localparam int unsigned AccW = 11;
  localparam int unsigned DivW = 8;
  localparam int unsigned SarDivW = 6;
  localparam logic [DivW-1:0] ModHalf = DivW'(MOD_DIV / 2);
  localparam logic [DivW-1:0] ModLast = DivW'(MOD_DIV - 1);
  localparam logic [SarDivW-1:0] SarLast = SarDivW'(msbc_pkg::SarDiv - 1);
  localparam logic [4:0] SmpLast = 5'(msbc_pkg::SampleCycles - 1);
  localparam logic [4:0] CnvLast = 5'(msbc_pkg::SampleCycles + msbc_pkg::ConvCycles - 1);
  localparam logic [AccW-1:0] OsrLast = AccW'(OSR - 1);
  localparam logic [3:0] ScanLast = 4'(msbc_pkg::NumScanCh - 1);
  localparam logic [15:0] OsrHalf = 16'(OSR / 2);
  // Out-of-range divider keeps the modulators unclocked
  localparam int unsigned ModHz = msbc_pkg::SysClkHz / MOD_DIV;
  localparam bit ModInRange = (ModHz >= msbc_pkg::ModMinHz) && (ModHz <= msbc_pkg::ModMaxHz);

  typedef struct packed {
    // Control and modulation clock
    logic [1:0]           ctrl;
    logic [DivW-1:0]      modCnt;
    logic                 modClk;
    // Stream capture and decimation
    logic [2:0]           bsMeta;
    logic [2:0]           bsSync;
    logic [AccW-1:0]      osrCnt;
    logic [2:0][AccW-1:0] acc;
    logic [2:0][15:0]     filtOut;
    logic                 strobe;
    logic [15:0]          sampleCnt;
    // SAR scan
    msbc_pkg::msbc_sar_e  sarState;
    logic [SarDivW-1:0]   sarDiv;
    logic [4:0]           sarCyc;
    logic [3:0]           sarCh;
    logic [15:0][15:0]    sarRes;
    logic                 scanDone;
    // Bus data phase
    logic                 dpSel;
    logic                 dpWrite;
    logic [7:0]           dpAddr;
    logic [31:0]          rdata;
  } msbc_state_s;

  msbc_state_s st_reg;
  msbc_state_s st_next;

  logic        modEn;
  logic        modRise;
  logic        sarTick;
  logic [15:0] sarWord;

  // ==========================================================
  // Per-converter ones count and signed result
  logic [msbc_pkg::NumConv-1:0][AccW-1:0] accSum;
  logic [msbc_pkg::NumConv-1:0][15:0]     filtRes;

  for (genvar g = 0; g < msbc_pkg::NumConv; g++) begin : g_conv
    assign accSum[g]  = st_reg.acc[g] + AccW'(st_reg.bsSync[g]);
    assign filtRes[g] = 16'(accSum[g]) - OsrHalf;
  end

  // ==========================================================
  // Combinational
  always_comb begin
    st_next  = st_reg;
    modEn    = st_reg.ctrl[msbc_pkg::CtrlEnBit] && ModInRange;
    modRise  = 1'b0;
    sarTick  = 1'b0;
    sarWord  = '0;

    // ==========================================================
    // Modulation clock divider, half high and half low
    if (!modEn) begin
      st_next.modCnt = '0;
      st_next.modClk = 1'b0;
    end else if (st_reg.modCnt == ModLast) begin
      st_next.modCnt = '0;
      st_next.modClk = 1'b1;
    end else begin
      st_next.modCnt = st_reg.modCnt + 1'b1;
      if (st_reg.modCnt == ModHalf - 1'b1) begin
        st_next.modClk = 1'b0;
      end
    end
    // Capture on the rising edge of the outgoing clock
    modRise = modEn && (st_reg.modCnt == ModLast);

    // ==========================================================
    // Two-flop sync of the modulator streams
    st_next.bsMeta = bitstreamIn;
    st_next.bsSync = st_reg.bsMeta;

    // ==========================================================
    // Decimation, one shared counter keeps all filters in lock-step
    st_next.strobe = 1'b0;
    if (!modEn) begin
      st_next.osrCnt = '0;
      st_next.acc    = '0;
    end else if (modRise) begin
      for (int i = 0; i < msbc_pkg::NumConv; i++) begin
        if (st_reg.osrCnt == OsrLast) begin
          // Ones count minus half the ratio gives a signed result
          st_next.filtOut[i] = filtRes[i];
          st_next.acc[i]     = '0;
        end else begin
          st_next.acc[i] = accSum[i];
        end
      end
      if (st_reg.osrCnt == OsrLast) begin
        st_next.osrCnt    = '0;
        st_next.strobe    = 1'b1;
        st_next.sampleCnt = st_reg.sampleCnt + 1'b1;
      end else begin
        st_next.osrCnt = st_reg.osrCnt + 1'b1;
      end
    end

    // ==========================================================
    // 4 MHz SAR clock enable
    if (st_reg.sarDiv == SarLast) begin
      st_next.sarDiv = '0;
      sarTick = 1'b1;
    end else begin
      st_next.sarDiv = st_reg.sarDiv + 1'b1;
    end

    // ==========================================================
    // Result format
    if (st_reg.ctrl[msbc_pkg::CtrlSignBit]) begin
      sarWord = {~sarAnalogCode[9], sarAnalogCode[8:0], 6'h00};
    end else begin
      sarWord = {6'h00, sarAnalogCode};
    end

    // ==========================================================
    // Autoscan sequencer
    st_next.scanDone = 1'b0;
    case (st_reg.sarState)
      msbc_pkg::SarIdle: begin
        if (st_reg.strobe) begin
          st_next.sarState = msbc_pkg::SarSample;
          // Restart the SAR clock so the first sample window is whole
          st_next.sarDiv   = '0;
          st_next.sarCh    = ScanLast;
          st_next.sarCyc   = '0;
        end
      end
      msbc_pkg::SarSample: begin
        if (sarTick) begin
          st_next.sarCyc = st_reg.sarCyc + 1'b1;
          if (st_reg.sarCyc == SmpLast) begin
            st_next.sarState = msbc_pkg::SarConv;
          end
        end
      end
      msbc_pkg::SarConv: begin
        if (sarTick) begin
          st_next.sarCyc = st_reg.sarCyc + 1'b1;
          if (st_reg.sarCyc == CnvLast) begin
            st_next.sarRes[st_reg.sarCh] = sarWord;
            st_next.sarCyc = '0;
            if (st_reg.sarCh == 4'h0) begin
              st_next.sarState = msbc_pkg::SarIdle;
              st_next.scanDone = 1'b1;
            end else begin
              st_next.sarCh    = st_reg.sarCh - 1'b1;
              st_next.sarState = msbc_pkg::SarSample;
            end
          end
        end
      end
      default: st_next.sarState = msbc_pkg::SarIdle;
    endcase

    // ==========================================================
    // AHB-Lite: capture address phase, act in data phase
    if (hready) begin
      st_next.dpSel   = hsel && htrans[1];
      st_next.dpWrite = hwrite;
      st_next.dpAddr  = haddr[7:0];
    end
    if (st_reg.dpSel && st_reg.dpWrite && st_reg.dpAddr == msbc_pkg::RegCtrl) begin
      st_next.ctrl = hwdata[1:0];
    end
    if (hready && hsel && htrans[1] && !hwrite) begin
      if (haddr[7:6] == msbc_pkg::RegSarBase[7:6]) begin
        st_next.rdata = {16'h0, st_reg.sarRes[haddr[5:2]]};
      end else begin
        case (haddr[7:0])
          // Forward a CTRL write still in its data phase
          msbc_pkg::RegCtrl:      st_next.rdata = {30'h0, st_next.ctrl};
          msbc_pkg::RegStatus:    st_next.rdata = {29'h0, st_reg.sarState};
          msbc_pkg::RegFilt0:     st_next.rdata = {16'h0, st_reg.filtOut[0]};
          msbc_pkg::RegFilt1:     st_next.rdata = {16'h0, st_reg.filtOut[1]};
          msbc_pkg::RegFilt2:     st_next.rdata = {16'h0, st_reg.filtOut[2]};
          msbc_pkg::RegSarData:   st_next.rdata = {16'h0, st_reg.sarRes[msbc_pkg::ChTemp]};
          msbc_pkg::RegSampleCnt: st_next.rdata = {16'h0, st_reg.sampleCnt};
          default:                st_next.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg          <= '0;
      st_reg.ctrl     <= msbc_pkg::CtrlReset;
      st_reg.sarState <= msbc_pkg::SarIdle;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs
  // Bus response, zero wait and always OKAY
  assign hrdata       = st_reg.rdata;
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  // Modulator link
  assign modClk       = st_reg.modClk;
  // SAR side and sample events
  assign sarChannel   = st_reg.sarCh;
  assign sarSampling  = (st_reg.sarState == msbc_pkg::SarSample);
  assign sampleStrobe = st_reg.strobe;
  assign scanDone     = st_reg.scanDone;

  logic unusedBits;
  assign unusedBits = ^{haddr[31:8], hsize, hwdata[31:2]};

endmodule

`default_nettype wire

/* File: msbc_pkg.sv */
// Constants and types for the modulator bit-stream sampling control block
package msbc_pkg;

  // ==========================================================
  // Clocking
  localparam int unsigned SysClkHz     = 200_000_000;
  localparam int unsigned RefSysClkHz  = 25_165_824;
  localparam int unsigned ModClkHz     = 5_033_165;
  localparam int unsigned ModDiv       = 40;
  localparam int unsigned SarClkHz     = 4_000_000;
  localparam int unsigned SarDiv       = SysClkHz / SarClkHz;
  localparam int unsigned ModMinHz     = 5_000_000;
  localparam int unsigned ModMaxHz     = 20_000_000;

  // ==========================================================
  // Filter and scan
  localparam int unsigned Osr          = 1024;
  localparam int unsigned NumConv      = 3;
  localparam int unsigned NumScanCh    = 16;
  localparam int unsigned SampleCycles = 8;
  localparam int unsigned ConvCycles   = 12;
  localparam int unsigned SarBits      = 10;
  localparam int unsigned ResBits      = 16;
  localparam logic [3:0]  ChTemp       = 4'ha;
  localparam logic [3:0]  ChPhase1V    = 4'h5;
  localparam logic [3:0]  ChPhase2V    = 4'h4;
  localparam logic [3:0]  ChPhase3V    = 4'h3;

  // ==========================================================
  // Register map (word offsets in bytes)
  localparam logic [7:0] RegCtrl       = 8'h00;
  localparam logic [7:0] RegStatus     = 8'h04;
  localparam logic [7:0] RegFilt0      = 8'h08;
  localparam logic [7:0] RegFilt1      = 8'h0c;
  localparam logic [7:0] RegFilt2      = 8'h10;
  localparam logic [7:0] RegSarData    = 8'h14;
  localparam logic [7:0] RegSampleCnt  = 8'h18;
  localparam logic [7:0] RegSarBase    = 8'h40;
  localparam int unsigned CtrlEnBit    = 0;
  localparam int unsigned CtrlSignBit  = 1;
  localparam logic [1:0] CtrlReset     = 2'h2;

  // ==========================================================
  // SAR sequencer states
  typedef enum logic [2:0] {
    SarIdle   = 3'b001,
    SarSample = 3'b010,
    SarConv   = 3'b100
  } msbc_sar_e;

endpackage

/* File: msbc_mod_model.sv */
// Behavioural model of the three isolated modulators
`timescale 1ns/1ps
`default_nettype none
module msbc_mod_model (
  input  wire logic       modClk,
  input  wire logic [5:0] mode,
  output logic      [2:0] bitstreamIn
);
  logic tgl = 1'b0;
  initial bitstreamIn = 3'h0;
  // Shared clock; per phase 0 zeros, 1 ones, 2 or 3 alternating
  always @(posedge modClk) begin
    tgl <= ~tgl;
    for (int i = 0; i < 3; i++) begin
      bitstreamIn[i] <= mode[2*i+1] ? tgl : mode[2*i];
    end
  end
endmodule
`default_nettype wire

/* File: msbc_top_sva.sv */
// Concurrent checks on the sampling control ports
`timescale 1ns/1ps
`default_nettype none
module msbc_top_sva #(
  parameter int unsigned MOD_DIV = 40,
  parameter int unsigned OSR     = 1024
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       modClk,
  input wire logic       sampleStrobe,
  input wire logic       sarSampling,
  input wire logic [3:0] sarChannel,
  input wire logic       scanDone
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic        modPrev;
  logic        seen;
  logic        inScan;
  logic [15:0] runCnt;
  logic [15:0] riseCnt;
  logic [15:0] sampCnt;
  logic [15:0] gapCnt;
  logic [3:0]  lastCh;
  always_ff @(posedge clk) begin
    modPrev <= modClk;
    sampCnt <= sarSampling ? sampCnt + 16'h1 : 16'h0;
    gapCnt  <= $rose(sarSampling) ? 16'h0 : gapCnt + 16'h1;
    if (!rst_n) begin
      seen    <= 1'b0;
      inScan  <= 1'b0;
      runCnt  <= 16'h0;
      riseCnt <= 16'h0;
      lastCh  <= 4'h0;
    end else begin
      runCnt  <= (modClk != modPrev) ? 16'h0 : runCnt + 16'h1;
      riseCnt <= sampleStrobe ? 16'(modClk && !modPrev) : riseCnt + 16'(modClk && !modPrev);
      seen    <= seen | sampleStrobe;
      inScan  <= scanDone ? 1'b0 : (inScan | $rose(sarSampling));
      lastCh  <= $fell(sarSampling) ? sarChannel : lastCh;
    end
  end
  a_mod_high: assert property ($fell(modClk) |-> runCnt == 16'(MOD_DIV / 2 - 1))
    else $error("modulation clock high time wrong");
  a_mod_low: assert property ($rose(modClk) && runCnt < 16'(MOD_DIV)
    |-> runCnt == 16'(MOD_DIV / 2 - 1))
    else $error("modulation clock low time wrong");
  a_strobe_pulse: assert property (sampleStrobe |=> !sampleStrobe)
    else $error("sample strobe longer than one cycle");
  a_strobe_period: assert property (sampleStrobe && seen |-> riseCnt == 16'(OSR))
    else $error("sample strobe spacing wrong");
  a_scan_start: assert property (sampleStrobe && !inScan |-> ##[1:51] sarSampling)
    else $error("trigger did not start a scan");
  a_sample_len: assert property ($fell(sarSampling) |-> sampCnt == 16'd400)
    else $error("sample window length wrong");
  a_chan_gap: assert property ($rose(sarSampling) && inScan |-> gapCnt == 16'd999)
    else $error("channel spacing wrong");
  a_chan_order: assert property ($fell(sarSampling) |-> sarChannel == 4'(lastCh - 4'h1))
    else $error("scan channel order wrong");
  a_scan_end: assert property (scanDone |-> (lastCh == 4'h0) ##1 !scanDone)
    else $error("scan end misplaced");
  c_strobe: cover property (sampleStrobe && seen);
  c_scan: cover property (scanDone);
  c_chan: cover property ($rose(sarSampling) && inScan);
endmodule
`default_nettype wire

/* File: msbc_top_tb.sv */
// Self-checking bench for the sampling control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin errCount++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module msbc_top_tb;
  localparam int unsigned ModDivTb = 40;
  localparam int unsigned OsrTb    = 8;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b1;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [5:0]  mode = 6'h24;
  logic [5:0]  codeLow = 6'h3f;
  logic [31:0] hrdata;
  logic [2:0]  bitstreamIn;
  logic [3:0]  sarChannel;
  logic [9:0]  sarAnalogCode;
  logic        hready, hreadyout, hresp, modClk, sarSampling, sampleStrobe, scanDone;
  int          errCount = 0;
  int          checksDone = 0;
  int          cycles = 0;
  assign hready = hreadyout;
  assign sarAnalogCode = {sarChannel, codeLow};
  msbc_top #(.MOD_DIV(ModDivTb), .OSR(OsrTb)) u_msbc_top (.clk(clk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .modClk(modClk), .bitstreamIn(bitstreamIn),
    .sarAnalogCode(sarAnalogCode), .sarChannel(sarChannel), .sarSampling(sarSampling),
    .sampleStrobe(sampleStrobe), .scanDone(scanDone));
  msbc_mod_model u_msbc_mod_model (.modClk(modClk), .mode(mode), .bitstreamIn(bitstreamIn));
  initial forever #2.5 clk = ~clk;
  task automatic tallyAndFinish();
    if (errCount == 0 && checksDone > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      errCount++;
      tallyAndFinish();
    end
  end
  // ==========================================================
  // Bus cycles and expectations
  task automatic busXfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                         output logic [31:0] d);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    d = hrdata;
  endtask
  task automatic rdChk(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] d;
    busXfer(1'b0, a, 32'h0, d);
    `CHK(d & m, e & m)
    `CHK(hresp, 1'b0)
  endtask
  function automatic logic [31:0] filtExp(input logic [1:0] m);
    filtExp = {16'h0, m[1] ? 16'h0 : (m[0] ? 16'(OsrTb / 2) : -16'(OsrTb / 2))};
  endfunction
  function automatic logic [31:0] sarExp(input logic [3:0] ch, input logic sgn);
    logic [9:0] c;
    c = {ch, codeLow};
    sarExp = sgn ? {16'h0, ~c[9], c[8:0], 6'h0} : {22'h0, c};
  endfunction
  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] d;
    d = $urandom(32'haa4819c1);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdChk(32'h0, 32'h2, 32'hffffffff);
    rdChk(32'h30, 32'h0, 32'hffffffff);
    rdChk(32'h4, 32'h1, 32'hffffffff);
    repeat (40) @(posedge clk);
    busXfer(1'b1, 32'h0, 32'h3, d);
    for (int s = 0; s < 2; s++) begin
      if (s == 1) begin
        mode <= 6'($urandom);
        codeLow <= 6'($urandom);
        busXfer(1'b1, 32'h0, 32'h1, d);
      end
      repeat (3) do @(posedge clk); while (sampleStrobe !== 1'b1);
      for (int i = 0; i < 3; i++) begin
        rdChk(32'h8 + 32'(4 * i), filtExp(mode[2*i+:2]), 32'hffffffff);
      end
      if (s == 0) begin
        rdChk(32'h18, 32'h3, 32'hffffffff);
      end
      repeat (2) do @(posedge clk); while (scanDone !== 1'b1);
      for (int ch = 0; ch < 16; ch++) begin
        rdChk(32'h40 + 32'(4 * ch), sarExp(4'(ch), s == 0), 32'hffff);
      end
      rdChk(32'h14, sarExp(4'ha, s == 0), 32'hffff);
    end
    busXfer(1'b1, 32'h0, 32'h0, d);
    repeat (2 * ModDivTb) @(posedge clk);
    `CHK(modClk, 1'b0)
    tallyAndFinish();
  end
endmodule
bind msbc_top msbc_top_sva #(.MOD_DIV(MOD_DIV), .OSR(OSR)) u_msbc_top_sva (.clk(clk),
  .rst_n(rst_n), .modClk(modClk), .sampleStrobe(sampleStrobe), .sarSampling(sarSampling),
  .sarChannel(sarChannel), .scanDone(scanDone));
`default_nettype wire
